/* File: verilog/pcm_pkg.sv */
// Package with addresses, field layout, presets and timing for the clock mode control block.
package pcm_pkg;
    // Register map and width.
    localparam int          REG_W          = 16;
    localparam logic [15:0] CLK_MODE_ADDR  = 16'h0058;
    // Field positions inside clock_mode_config.
    localparam int          MULT_LSB       = 12;
    localparam int          MULT_W         = 4;
    localparam int          HALF_BIT       = 11;
    localparam int          LOCK_LSB       = 3;
    localparam int          LOCK_W         = 8;
    localparam int          PLL_ON_BIT     = 2;
    localparam int          PLL_MODE_BIT   = 1;
    localparam int          LOCKED_BIT     = 0;
    // Preset values chosen by the three select pins, indexed by {a,b,c}.
    localparam logic [15:0] PRESET_000     = 16'h0000;
    localparam logic [15:0] PRESET_001     = 16'h1000;
    localparam logic [15:0] PRESET_010     = 16'h2000;
    localparam logic [15:0] PRESET_011     = 16'h0000;
    localparam logic [15:0] PRESET_100     = 16'h4000;
    localparam logic [15:0] PRESET_101     = 16'h0007;
    localparam logic [15:0] PRESET_110     = 16'h6000;
    localparam logic [15:0] PRESET_111     = 16'h7000;
    localparam logic [2:0]  SEL_STOP       = 3'h3;
    localparam logic [2:0]  SEL_OSC        = 3'h4;
    // Reference cycles of lock wait per unit of the lock count field.
    localparam int          LOCK_SCALE     = 16;
    localparam int          PERIOD_W       = 16;
    // Clock output states.
    typedef enum logic [3:0] {
        PCM_STOP    = 4'h1,
        PCM_DIV     = 4'h2,
        PCM_ACQUIRE = 4'h4,
        PCM_PLL     = 4'h8
    } pcm_state_t;
endpackage

/* File: verilog/pcm_clock_mode.sv */
// Clock generator mode control: mode register, strap preset, divider, lock timer, multiplier.
// Function
// - At reset the mode register takes a preset set only by the three select pins.
// - Patterns 000, 001, 010, 110 preset 0000h, 1000h, 2000h, 6000h: divide by two.
// - Pattern 100 presets 4000h and enables the internal oscillator, divide by two.
// - Pattern 101 presets 0007h: loop mode, multiply by one, external source.
// - The mode register is sixteen bits at address 0058h and sets loop, divider and ratio; stop and oscillator enable come only from the select pins.
// - Loop mode multiplies the reference by one of 24 ratios chosen in the register.
// - Divider mode gives the reference divided by two or by four.
// - In divider mode the loop may be switched off completely to save power.
// - Software switches the loop on or off directly through the mode register.
// - A lock timer holds off the switch to the multiplied clock until lock.
// - A new loop start first acquires; only after lock is the multiplied clock used.
`timescale 1ns/10ps
module pcm_clock_mode
    import pcm_pkg::*;
#(
    parameter int LOCK_SCALE_P = LOCK_SCALE
) (
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        clock_select_pin_a_i,
    input  wire logic        clock_select_pin_b_i,
    input  wire logic        clock_select_pin_c_i,
    input  wire logic        reference_clock_input_i,
    output logic             crystal_drive_pin_o,
    output logic             crystal_drive_pin_oe_o,
    output logic             dev_clk_o,
    output logic             pll_enable_o,
    output logic             osc_enable_o,
    output logic             clk_stopped_o
);

    // Elaboration check: the scaled lock count must still fit the 16-bit lock timer.
    if (LOCK_SCALE_P < 1 || LOCK_SCALE_P > 256) begin : g_bad_scale
        $error("LOCK_SCALE_P must lie in 1..256");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register, strap capture and decode.

    logic [15:0]       mode_reg;
    logic              strap_pending;
    logic              locked;
    logic              ref_q;
    logic              ref_rise;
    logic              mode_wr;
    logic [2:0]        sel_pins;
    logic [15:0]       preset;
    logic [MULT_W-1:0] mult;
    logic              half;
    logic              pll_on;
    logic              pll_mode;
    logic [LOCK_W-1:0] lock_cnt_field;
    pcm_state_t        state;

    assign sel_pins       = {clock_select_pin_a_i, clock_select_pin_b_i, clock_select_pin_c_i};
    assign mode_wr        = wr_i && (addr_i == CLK_MODE_ADDR) && !strap_pending;
    assign mult           = mode_reg[MULT_LSB +: MULT_W];
    assign half           = mode_reg[HALF_BIT];
    assign pll_on         = mode_reg[PLL_ON_BIT];
    assign pll_mode       = mode_reg[PLL_MODE_BIT];
    assign lock_cnt_field = mode_reg[LOCK_LSB +: LOCK_W];
    assign ref_rise       = reference_clock_input_i && !ref_q;

    // Preset table, selected purely by the pin pattern.
    always_comb begin
        unique case (sel_pins)
            3'h0:    preset = PRESET_000;
            3'h1:    preset = PRESET_001;
            3'h2:    preset = PRESET_010;
            3'h3:    preset = PRESET_011;
            3'h4:    preset = PRESET_100;
            3'h5:    preset = PRESET_101;
            3'h6:    preset = PRESET_110;
            default: preset = PRESET_111;
        endcase
    end

    // The pins are caught one clock after reset release, since an async reset may only load constants.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strap_pending <= 1'b1;
            mode_reg      <= 16'h0000;
            osc_enable_o  <= 1'b0;
            clk_stopped_o <= 1'b0;
        end else if (strap_pending) begin
            strap_pending <= 1'b0;
            mode_reg      <= preset;
            osc_enable_o  <= (sel_pins == SEL_OSC);
            clk_stopped_o <= (sel_pins == SEL_STOP);
        end else if (mode_wr) begin
            mode_reg      <= {wdata_i[15:1], 1'b0};
        end
    end

    // Read data is registered; any other address reads zero. Lock status is live.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i && addr_i == CLK_MODE_ADDR) begin
            rdata_o <= {mode_reg[15:1], locked};
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // The loop is powered only while the pll_on bit of the mode register is set and the clock is not stopped; divider mode may run with it off.
    assign pll_enable_o = pll_on && !clk_stopped_o;

    // Crystal amplifier drives the opposite level of the reference while the oscillator is on.
    assign crystal_drive_pin_o    = !reference_clock_input_i;
    assign crystal_drive_pin_oe_o = osc_enable_o;

    ////////////////////////////////////////////////////////////////////////////////
    // Reference edge detect and period measurement.

    logic [PERIOD_W-1:0] period_cnt;
    logic [PERIOD_W-1:0] ref_period;
    logic [1:0]          rise_cnt;
    logic                period_ok;

    // The first rise after reset may be false and the second ends a cut period,
    // so the measured period is trusted only from the third rise on.
    assign period_ok = (rise_cnt == 2'h3);

    // Period of the reference in mclk cycles, used to synthesise the multiplied clock.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ref_q      <= 1'b0;
            period_cnt <= '0;
            ref_period <= '0;
            rise_cnt   <= 2'h0;
        end else begin
            ref_q <= reference_clock_input_i;
            if (ref_rise) begin
                ref_period <= period_cnt + PERIOD_W'(1);
                period_cnt <= '0;
                if (rise_cnt != 2'h3) begin
                    rise_cnt <= rise_cnt + 2'h1;
                end
            end else if (period_cnt != '1) begin
                period_cnt <= period_cnt + PERIOD_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode state machine and lock timer.

    logic        want_pll;
    logic [15:0] lock_timer;

    assign want_pll = pll_mode && pll_on;

    // Any write that restarts or reconfigures the loop sends it back through acquisition.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state      <= PCM_DIV;
            lock_timer <= 16'h0000;
        end else if (clk_stopped_o) begin
            state      <= PCM_STOP;
        end else if (strap_pending || mode_wr) begin
            state      <= PCM_ACQUIRE;
            lock_timer <= 16'(LOCK_SCALE_P) * 16'(lock_cnt_field);
            if (strap_pending) begin
                lock_timer <= 16'(LOCK_SCALE_P) * 16'(preset[LOCK_LSB +: LOCK_W]);
            end else begin
                lock_timer <= 16'(LOCK_SCALE_P) * 16'(wdata_i[LOCK_LSB +: LOCK_W]);
            end
        end else begin
            unique case (state)
                PCM_STOP: begin
                    state <= PCM_STOP;
                end
                PCM_DIV: begin
                    state <= PCM_DIV;
                end
                PCM_ACQUIRE: begin
                    if (!want_pll) begin
                        state <= PCM_DIV;
                    end else if (lock_timer == 16'h0000) begin
                        state <= PCM_PLL;
                    end else if (ref_rise) begin
                        lock_timer <= lock_timer - 16'h0001;
                    end
                end
                PCM_PLL: begin
                    state <= want_pll ? PCM_PLL : PCM_DIV;
                end
                default: state <= PCM_DIV;
            endcase
        end
    end

    assign locked = (state == PCM_PLL);

    ////////////////////////////////////////////////////////////////////////////////
    // Clock synthesis: divider and multiplier.

    logic [1:0]  div_cnt;
    logic        div_clk;
    logic [20:0] nco_acc;
    logic [20:0] nco_step;
    logic [20:0] nco_limit;
    logic        mul_clk;

    // Ratio is (mult+1), or (mult+1)/2 with the half bit: 16 + 8 distinct values.
    assign nco_step  = 21'(({1'b0, mult} + 5'h01)) << 1;
    assign nco_limit = half ? 21'(ref_period) << 1 : 21'(ref_period);

    // Divider toggles on reference rising edges; four-way count for the divide by four.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_cnt <= 2'h0;
            div_clk <= 1'b0;
        end else if (ref_rise) begin
            div_cnt <= div_cnt + 2'h1;
            if (!(half && !pll_mode) || div_cnt[0]) begin
                div_clk <= !div_clk;
            end
        end
    end

    // Accumulator toggles 2*ratio times per reference period; jitter is one mclk at most.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            nco_acc <= 21'h000000;
            mul_clk <= 1'b0;
        end else if (state != PCM_PLL || !period_ok) begin
            nco_acc <= 21'h000000;
            mul_clk <= 1'b0;
        end else if (nco_acc + nco_step >= nco_limit) begin
            nco_acc <= nco_acc + nco_step - nco_limit;
            mul_clk <= !mul_clk;
        end else begin
            nco_acc <= nco_acc + nco_step;
        end
    end

    // Output clock is registered so that the selection never glitches the pin.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dev_clk_o <= 1'b0;
        end else if (clk_stopped_o) begin
            // The stop flag acts at once; the state only reaches STOP a cycle later.
            dev_clk_o <= 1'b0;
        end else begin
            unique case (state)
                PCM_STOP:    dev_clk_o <= 1'b0;
                PCM_PLL:     dev_clk_o <= mul_clk;
                default:     dev_clk_o <= div_clk;
            endcase
        end
    end

endmodule // pcm_clock_mode

/* File: verif/pcm_ref_src.sv */
// Reference clock source standing in for the crystal or external oscillator.
`timescale 1ns/10ps
module pcm_ref_src #(
    parameter int HALF_NS = 500
) (
    output logic ref_clk_o
);
    // A crystal never pauses, so it runs free; the offset keeps edges off mclk.
    initial begin
        ref_clk_o = 1'b0;
        #3;
        forever #(HALF_NS) ref_clk_o = ~ref_clk_o;
    end
endmodule // pcm_ref_src

/* File: verif/pcm_clock_mode_sva.sv */
// Checker for the clock mode control block, bound to its ports.
`timescale 1ns/10ps
module pcm_clock_mode_sva
    import pcm_pkg::*;
#(
    parameter int LOCK_SCALE_P = LOCK_SCALE
) (
    input wire logic        mclk_i,
    input wire logic        arst_n_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] rdata_o,
    input wire logic        clock_select_pin_a_i,
    input wire logic        clock_select_pin_b_i,
    input wire logic        clock_select_pin_c_i,
    input wire logic        reference_clock_input_i,
    input wire logic        crystal_drive_pin_o,
    input wire logic        crystal_drive_pin_oe_o,
    input wire logic        dev_clk_o,
    input wire logic        pll_enable_o,
    input wire logic        osc_enable_o,
    input wire logic        clk_stopped_o
);
    logic [15:0] last_wr;
    logic        wr_seen;
    logic [1:0]  age;
    logic [2:0]  sel;
    // Strap pattern as {a,b,c}; the bench only moves it ahead of a reset.
    assign sel = {clock_select_pin_a_i, clock_select_pin_b_i, clock_select_pin_c_i};
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    // Last word written; readback is only judged once a write has landed.
    always_ff @(posedge mclk_i) if (wr_i && addr_i == CLK_MODE_ADDR) last_wr <= wdata_i;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) wr_seen <= 1'b0;
        else if (wr_i && addr_i == CLK_MODE_ADDR) wr_seen <= 1'b1;
    end
    // Straps load at the first edge, so their flags are judged from the second on.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) age <= 2'h0;
        else if (age != 2'h2) age <= age + 2'h1;
    end
    sequence s_wr_lock; wr_i && addr_i == CLK_MODE_ADDR && wdata_i[10:3] != 8'h00; endsequence
    sequence s_rd; rd_i && !wr_i && addr_i == CLK_MODE_ADDR; endsequence
    property p_idle; !(rd_i && addr_i == CLK_MODE_ADDR) |=> rdata_o == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero");
    property p_rdback; wr_seen && rd_i && !wr_i && addr_i == CLK_MODE_ADDR
        |=> rdata_o[15:1] == last_wr[15:1]; endproperty
    a_rdback: assert property (p_rdback) else $error("readback wrong");
    property p_acq; s_wr_lock ##1 s_rd |=> !rdata_o[0]; endproperty
    a_acq: assert property (p_acq) else $error("locked before lock wait");
    property p_lock_off; s_rd ##0 !pll_enable_o |=> !rdata_o[0]; endproperty
    a_lock_off: assert property (p_lock_off) else $error("locked with loop off");
    property p_xtal; crystal_drive_pin_oe_o |-> crystal_drive_pin_o == !reference_clock_input_i;
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal drive wrong");
    property p_stop; clk_stopped_o |-> !dev_clk_o && !pll_enable_o; endproperty
    a_stop: assert property (p_stop) else $error("clock runs in stop mode");
    property p_strap; age == 2'h2 |-> $stable(clk_stopped_o) && $stable(osc_enable_o)
        && $stable(crystal_drive_pin_oe_o); endproperty
    a_strap: assert property (p_strap) else $error("strap flags moved");
    property p_oe; age != 2'h0 |-> crystal_drive_pin_oe_o == osc_enable_o; endproperty
    a_oe: assert property (p_oe) else $error("drive enable differs");
    // Second edge after release: the flags must match the pattern that was strapped.
    property p_sel; age == 2'h1 |-> osc_enable_o == (sel == SEL_OSC)
        && clk_stopped_o == (sel == SEL_STOP); endproperty
    a_sel: assert property (p_sel) else $error("strap flags wrong");
endmodule // pcm_clock_mode_sva
bind pcm_clock_mode pcm_clock_mode_sva #(.LOCK_SCALE_P(LOCK_SCALE_P)) u_sva (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .clock_select_pin_a_i(clock_select_pin_a_i),
    .clock_select_pin_b_i(clock_select_pin_b_i), .clock_select_pin_c_i(clock_select_pin_c_i),
    .reference_clock_input_i(reference_clock_input_i), .crystal_drive_pin_o(crystal_drive_pin_o),
    .crystal_drive_pin_oe_o(crystal_drive_pin_oe_o), .dev_clk_o(dev_clk_o),
    .pll_enable_o(pll_enable_o), .osc_enable_o(osc_enable_o), .clk_stopped_o(clk_stopped_o));

/* File: verif/testbench.sv */
// Self-checking testbench for the clock mode control block.
`timescale 1ns/10ps
module testbench;
    import pcm_pkg::*;
    localparam int LS = 2;
    logic        mclk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [2:0]  pins = 3'h0;
    logic        ref_clk, xd, xd_oe, dev_clk, pll_en, osc_en, stopped;
    logic [15:0] rdata_o, v;
    logic [16:0] lfsr = 17'h103B8;
    int          n_errors = 0;
    int          n_checks = 0;
    int          n;
    // Bench clock at 40 MHz; the reference below is 40 clock cycles long.
    always #12.5 mclk_i = ~mclk_i;
    pcm_ref_src #(.HALF_NS(500)) pcm_ref_src_inst (.ref_clk_o(ref_clk));
    pcm_clock_mode #(.LOCK_SCALE_P(LS)) pcm_clock_mode_inst (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .clock_select_pin_a_i(pins[2]),
        .clock_select_pin_b_i(pins[1]), .clock_select_pin_c_i(pins[0]),
        .reference_clock_input_i(ref_clk), .crystal_drive_pin_o(xd),
        .crystal_drive_pin_oe_o(xd_oe), .dev_clk_o(dev_clk), .pll_enable_o(pll_en),
        .osc_enable_o(osc_en), .clk_stopped_o(stopped));
    function automatic logic [16:0] lfsr_next(logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    function automatic logic [15:0] exp_preset(logic [2:0] p);
        logic [15:0] t [8];
        t = '{16'h0000, 16'h1000, 16'h2000, 16'h0000, 16'h4000, 16'h0007, 16'h6000, 16'h7000};
        return t[p];
    endfunction
    // Edge counts drift with reference phase, so a small slack is allowed.
    function automatic logic near(int seen, int exp, int tol);
        return (seen >= exp - tol) && (seen <= exp + tol);
    endfunction
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge mclk_i);
        arst_n_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    // Write and read back on the very next edge, as the bus allows.
    task automatic wr_rd(logic [15:0] a, logic [15:0] d, output logic [15:0] q);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 q = rdata_o;
    endtask
    task automatic rd(logic [15:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // Count device clock rising edges over sixteen reference periods.
    task automatic count_rise(output int cnt);
        logic last;
        cnt = 0;
        last = dev_clk;
        repeat (640) begin
            @(posedge mclk_i);
            #1 if (dev_clk && !last) cnt++;
            last = dev_clk;
        end
    endtask
    // Watchdog sized well past the few thousand cycles the run needs.
    initial begin
        #1_000_000;
        n_errors++;
        close_out();
    end
    // Main sequence: every strap pattern, then register and clock behaviour.
    initial begin
        for (int p = 0; p < 8; p++) begin
            pins <= p[2:0];
            do_reset();
            repeat (4) @(posedge mclk_i);
            rd(CLK_MODE_ADDR, v);
            if (p != 3) begin
                check("preset", v, exp_preset(p[2:0]));
            end
            check("stopped", stopped, p == 3);
            check("osc", osc_en, p == 4);
            check("xd_oe", xd_oe, p == 4);
            // Stop mode must hold the device clock low for a whole window.
            if (p == 3) begin
                count_rise(n);
                check("stop_clk", 16'(n), 16'h0000);
            end
            // Times one: wait for three reference rises so the period is true.
            if (p == 5) begin
                repeat (120) @(posedge mclk_i);
                count_rise(n);
                check("pll_x1", near(n, 16, 1), 1'b1);
            end
        end
        pins <= 3'h0;
        do_reset();
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(CLK_MODE_ADDR, lfsr[15:0]);
            rd(CLK_MODE_ADDR, v);
            check("rdback", v[15:1], lfsr[15:1]);
            check("pll_en", pll_en, lfsr[2]);
        end
        wr(16'h0059, 16'hFFFF);
        rd(16'h0059, v);
        check("unmapped", v, 16'h0000);
        rd(CLK_MODE_ADDR, v);
        check("kept", v[15:1], lfsr[15:1]);
        wr(CLK_MODE_ADDR, 16'h0000);
        count_rise(n);
        check("div2", near(n, 8, 1), 1'b1);
        check("pll_off", pll_en, 1'b0);
        wr(CLK_MODE_ADDR, 16'h0800);
        count_rise(n);
        check("div4", near(n, 4, 1), 1'b1);
        wr(CLK_MODE_ADDR, 16'h300A);
        count_rise(n);
        check("mode_no_on", near(n, 8, 1), 1'b1);
        wr_rd(CLK_MODE_ADDR, 16'h300E, v);
        check("acquire", v[0], 1'b0);
        repeat (3 * LS * 40) @(posedge mclk_i);
        rd(CLK_MODE_ADDR, v);
        check("locked", v[0], 1'b1);
        count_rise(n);
        check("mult4", near(n, 64, 2), 1'b1);
        close_out();
    end
endmodule // testbench
